// ---- pkg/gcfg_pkg.sv ----
package gcfg_pkg;
    // register offsets on the host register port
    localparam logic [7:0] ADDR_BANK = 8'h00;
    localparam logic [7:0] ADDR_MCFG1 = 8'h09;
    localparam logic [7:0] ADDR_MCFG2 = 8'h0A;
    localparam logic [7:0] ADDR_PLL_ENABLE_REG = 8'h0B;
    localparam logic [7:0] ADDR_INPUT_CLOCK_ENABLE_REG = 8'h0C;
    localparam logic [7:0] ADDR_OUTPUT_CLOCK_ENABLE_REG = 8'h0D;
    localparam logic [7:0] ADDR_PCFG1 = 8'h0E;
    localparam logic [7:0] ADDR_PSTATE = 8'h0F;
    localparam logic [7:0] ADDR_STATUS_BASE = 8'h40;
    // writable bit masks, reserved bits stay zero
    localparam logic [7:0] MASK_BANK = 8'h01;
    localparam logic [7:0] MASK_MCFG1 = 8'hBF;
    localparam logic [7:0] MASK_MCFG2 = 8'h60;
    localparam logic [7:0] MASK_PLL_ENABLE_REG = 8'h11;
    localparam logic [7:0] MASK_INPUT_CLOCK_ENABLE_REG = 8'h07;
    localparam logic [7:0] MASK_OUTPUT_CLOCK_ENABLE_REG = 8'h07;
    localparam logic [7:0] MASK_PCFG1 = 8'hFF;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    // field positions
    localparam int BIT_BANK = 0;
    localparam int BIT_SOFT_RST = 7;
    localparam int BIT_MCLK_IN1 = 5;
    localparam int BIT_MCLK_SRC = 4;
    localparam int BIT_ROSC_PD = 3;
    localparam int BIT_DBL = 2;
    localparam int POS_XMODE = 0;
    localparam int POS_EXTSRC = 5;
    localparam int BIT_NCO = 4;
    localparam int BIT_APLL = 0;
    localparam int POS_PIN0 = 0;
    localparam int POS_PIN1 = 4;
    // crystal pin modes
    localparam logic [1:0] XMODE_OFF = 2'h0;
    localparam logic [1:0] XMODE_XTAL = 2'h1;
    localparam logic [1:0] XMODE_SE = 2'h2;
    // pin configuration codes
    localparam logic [3:0] PIN_IN = 4'h0;
    localparam logic [3:0] PIN_IN_INV = 4'h1;
    localparam logic [3:0] PIN_OUT_LO = 4'h2;
    localparam logic [3:0] PIN_OUT_HI = 4'h3;
    localparam logic [3:0] PIN_ST = 4'h4;
    localparam logic [3:0] PIN_ST_INV = 4'h5;
    localparam logic [3:0] PIN_ST_OD0 = 4'h6;
    localparam logic [3:0] PIN_ST_OD1 = 4'h7;
    // master clock source choices
    typedef enum logic [1:0] {
        GCFG_MCLK_RING,
        GCFG_MCLK_XTAL,
        GCFG_MCLK_IN1
    } gcfg_mclk_t;
endpackage

// ---- pkg/gcfg_pin_if.sv ----
`timescale 1ns/100ps
// one pin's configuration and drive between top and pin driver
interface gcfg_pin_if;
    logic [3:0] cfg;
    logic [7:0] stat_sel;
    logic [7:0] stat_byte;
    logic pin_in;
    logic drv;
    logic drv_oe;
    logic level;
    modport ctrl (output cfg, output stat_sel, output stat_byte,
        output pin_in, input drv, input drv_oe, input level);
    modport drvr (input cfg, input stat_sel, input stat_byte,
        input pin_in, output drv, output drv_oe, output level);
endinterface

// ---- hdl/gcfg_pin_drv.sv ----
`timescale 1ns/100ps
// next drive and readable level of one configurable pin
module gcfg_pin_drv
    import gcfg_pkg::*;
(
    gcfg_pin_if.drvr p
);
    logic st_bit;

    // status bit chosen by the low three select bits
    always_comb begin
        st_bit = p.stat_byte[p.stat_sel[2:0]];
        p.drv = 1'b0;
        p.drv_oe = 1'b0;
        p.level = p.pin_in;
        case (p.cfg)
            PIN_IN: p.level = p.pin_in;
            PIN_IN_INV: p.level = ~p.pin_in;
            PIN_OUT_LO: begin
                p.drv_oe = 1'b1;
            end
            PIN_OUT_HI: begin
                p.drv = 1'b1;
                p.drv_oe = 1'b1;
            end
            PIN_ST: begin
                p.drv = st_bit;
                p.drv_oe = 1'b1;
            end
            PIN_ST_INV: begin
                p.drv = ~st_bit;
                p.drv_oe = 1'b1;
            end
            PIN_ST_OD0: p.drv_oe = ~st_bit;
            PIN_ST_OD1: p.drv_oe = st_bit;
            // unused codes leave the pin undriven
            default: p.drv_oe = 1'b0;
        endcase
    end
endmodule

// ---- hdl/gcfg_regs.sv ----
`timescale 1ns/100ps
//
// Notes on behaviour
// - Bank bit 0 maps registers (0) or internal memory (1) from address 1.
// - Soft reset bit 7 holds device reset and defaults all other fields.
// - Soft reset restores pin defaults latched at last hardware reset.
// - Bit 5 takes master clock from input one, overriding bit 4.
// - Bit 4 picks ring oscillator (0) or crystal pin (1); ring after reset.
// - Bit 3 powers down the ring oscillator.
// - Crystal pin mode: 00 off, 01 crystal, 10 single-ended, 11 unused.
// - Bits 6:5 pick switch source pin 0..3, only with switching enabled; the code passes them on always, flagged by ext_switch_valid.
// - Bit 4 powers the NCO/spread block; crystal source set up first.
// - Bit 0 enables the analog PLL; keep set for normal operation.
// - Input enable bits 0..2 enable input clocks one to three.
// - Output enable bits 0..2 enable output clocks one to three.
// - Pin codes: input, inverted input, drive low, drive high; 1xxx unused.
// - Codes 0100..0111 drive a status bit, plain, inverted or open-drain.
// - Present pin levels are readable in every mode; inverted input mode reads them inverted.
// - Pin 0 config is bits 3:0, pin 1 config bits 7:4.
// - Followed status bit is at 0x40 plus five-bit field, bit by three.
module gcfg_regs
    import gcfg_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // host register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // strapped defaults, sampled during hardware reset
    input wire logic [7:0] strap_pin_cfg,
    // status bytes for followed status bits, 32 registers
    input wire logic [255:0] status_bytes,
    input wire logic ext_switch_on,
    // configurable pins
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    // controls to the clock blocks
    output logic memory_bank_select,
    output logic device_in_reset,
    output gcfg_mclk_t mclk_select,
    output logic ring_osc_on,
    output logic clock_doubler_on,
    output logic [1:0] crystal_pin_mode,
    output logic [1:0] ext_switch_gpio_source,
    output logic ext_switch_valid,
    output logic nco_spread_block_on,
    output logic analog_pll_on,
    output logic [2:0] input_clk_on,
    output logic [2:0] output_clk_on,
    // per-pin status select, owned by a neighbouring register block
    input wire logic [7:0] pin0_status_select,
    input wire logic [7:0] pin1_status_select
);
    // an address width under 8 bits is refused, matching the 8-bit offsets in the package
    if (ADDR_W < 8) begin : g_addr_check
        $error("address width too small");
    end

    logic [7:0] bank_reg, bank_next;
    logic [7:0] mcfg1_reg, mcfg1_next;
    logic [7:0] mcfg2_reg, mcfg2_next;
    logic [7:0] pll_enable_reg_reg, pll_enable_reg_next;
    logic [7:0] input_clock_enable_reg_reg, input_clock_enable_reg_next;
    logic [7:0] output_clock_enable_reg_reg, output_clock_enable_reg_next;
    logic [7:0] pcfg1_reg, pcfg1_next;
    logic [7:0] strap_reg, strap_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] pout_reg, pout_next;
    logic [1:0] poe_reg, poe_next;
    logic [1:0] lvl;
    logic soft_rst;

    gcfg_pin_if p0 ();
    gcfg_pin_if p1 ();

    // masked write keeps reserved bits at zero
    function automatic logic [7:0] mwr(input logic [7:0] d,
                                       input logic [7:0] m);
        return d & m;
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        return a == ADDR_W'(off);
    endfunction

    assign soft_rst = mcfg1_reg[BIT_SOFT_RST];

    // pin drivers see their configuration field and followed byte
    assign p0.cfg = pcfg1_reg[POS_PIN0 +: 4];
    assign p1.cfg = pcfg1_reg[POS_PIN1 +: 4];
    assign p0.stat_sel = pin0_status_select;
    assign p1.stat_sel = pin1_status_select;
    assign p0.stat_byte = status_bytes[pin0_status_select[7:3]*8 +: 8];
    assign p1.stat_byte = status_bytes[pin1_status_select[7:3]*8 +: 8];
    assign p0.pin_in = pin_in[0];
    assign p1.pin_in = pin_in[1];
    assign lvl = {p1.level, p0.level};

    gcfg_pin_drv u_pin0 (.p(p0));
    gcfg_pin_drv u_pin1 (.p(p1));

    // register writes, hardware reset and soft reset
    always_comb begin
        bank_next = bank_reg;
        mcfg1_next = mcfg1_reg;
        mcfg2_next = mcfg2_reg;
        pll_enable_reg_next = pll_enable_reg_reg;
        input_clock_enable_reg_next = input_clock_enable_reg_reg;
        output_clock_enable_reg_next = output_clock_enable_reg_reg;
        pcfg1_next = pcfg1_reg;
        strap_next = strap_reg;
        if (rst) begin
            // strap captured only while the hardware reset is held
            strap_next = strap_pin_cfg;
            bank_next = RST_ZERO;
            mcfg1_next = RST_ZERO;
            mcfg2_next = RST_ZERO;
            pll_enable_reg_next = RST_ZERO;
            input_clock_enable_reg_next = RST_ZERO;
            output_clock_enable_reg_next = RST_ZERO;
            pcfg1_next = strap_pin_cfg;
        end else begin
            if (reg_wr && hit(reg_addr, ADDR_BANK))
                bank_next = mwr(reg_wdata, MASK_BANK);
            // device registers only while the register bank is mapped;
            // this hides the master config too, so bank 1 blocks soft reset
            if (reg_wr && !bank_reg[BIT_BANK]) begin
                if (hit(reg_addr, ADDR_MCFG1))
                    mcfg1_next = mwr(reg_wdata, MASK_MCFG1);
                if (hit(reg_addr, ADDR_MCFG2))
                    mcfg2_next = mwr(reg_wdata, MASK_MCFG2);
                if (hit(reg_addr, ADDR_PLL_ENABLE_REG))
                    pll_enable_reg_next = mwr(reg_wdata, MASK_PLL_ENABLE_REG);
                if (hit(reg_addr, ADDR_INPUT_CLOCK_ENABLE_REG))
                    input_clock_enable_reg_next = mwr(reg_wdata, MASK_INPUT_CLOCK_ENABLE_REG);
                if (hit(reg_addr, ADDR_OUTPUT_CLOCK_ENABLE_REG))
                    output_clock_enable_reg_next = mwr(reg_wdata, MASK_OUTPUT_CLOCK_ENABLE_REG);
                if (hit(reg_addr, ADDR_PCFG1))
                    pcfg1_next = mwr(reg_wdata, MASK_PCFG1);
            end
            // soft reset defaults everything but itself; straps not resampled
            if (soft_rst) begin
                bank_next = RST_ZERO;
                mcfg1_next[BIT_SOFT_RST-1:0] = RST_ZERO[BIT_SOFT_RST-1:0];
                mcfg2_next = RST_ZERO;
                pll_enable_reg_next = RST_ZERO;
                input_clock_enable_reg_next = RST_ZERO;
                output_clock_enable_reg_next = RST_ZERO;
                pcfg1_next = strap_reg;
            end
        end
    end

    // read port: one-cycle answer, unmapped reads give zero
    always_comb begin
        rdata_next = RST_ZERO;
        rvalid_next = reg_rd && !rst;
        if (reg_rd) begin
            if (hit(reg_addr, ADDR_BANK))
                rdata_next = bank_reg;
            else if (bank_reg[BIT_BANK])
                rdata_next = RST_ZERO;
            else if (hit(reg_addr, ADDR_MCFG1))
                rdata_next = mcfg1_reg;
            else if (hit(reg_addr, ADDR_MCFG2))
                rdata_next = mcfg2_reg;
            else if (hit(reg_addr, ADDR_PLL_ENABLE_REG))
                rdata_next = pll_enable_reg_reg;
            else if (hit(reg_addr, ADDR_INPUT_CLOCK_ENABLE_REG))
                rdata_next = input_clock_enable_reg_reg;
            else if (hit(reg_addr, ADDR_OUTPUT_CLOCK_ENABLE_REG))
                rdata_next = output_clock_enable_reg_reg;
            else if (hit(reg_addr, ADDR_PCFG1))
                rdata_next = pcfg1_reg;
            else if (hit(reg_addr, ADDR_PSTATE))
                rdata_next = {6'h00, lvl};
        end
    end

    // pin drive is registered so outputs come from flops
    always_comb begin
        pout_next = {p1.drv, p0.drv};
        poe_next = {p1.drv_oe, p0.drv_oe};
        if (rst || soft_rst)
            poe_next = 2'h0;
    end

    always_ff @(posedge mclk) begin
        bank_reg <= bank_next;
        mcfg1_reg <= mcfg1_next;
        mcfg2_reg <= mcfg2_next;
        pll_enable_reg_reg <= pll_enable_reg_next;
        input_clock_enable_reg_reg <= input_clock_enable_reg_next;
        output_clock_enable_reg_reg <= output_clock_enable_reg_next;
        pcfg1_reg <= pcfg1_next;
        strap_reg <= strap_next;
        rdata_reg <= rst ? RST_ZERO : rdata_next;
        rvalid_reg <= rvalid_next;
        pout_reg <= rst ? 2'h0 : pout_next;
        poe_reg <= poe_next;
    end

    // decoded controls, registered for clean outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            mclk_select <= GCFG_MCLK_RING;
            ring_osc_on <= 1'b1;
            device_in_reset <= 1'b1;
            memory_bank_select <= 1'b0;
            clock_doubler_on <= 1'b0;
            crystal_pin_mode <= XMODE_OFF;
            ext_switch_gpio_source <= 2'h0;
            ext_switch_valid <= 1'b0;
            nco_spread_block_on <= 1'b0;
            analog_pll_on <= 1'b0;
            input_clk_on <= 3'h0;
            output_clk_on <= 3'h0;
        end else begin
            if (mcfg1_next[BIT_MCLK_IN1])
                mclk_select <= GCFG_MCLK_IN1;
            else if (mcfg1_next[BIT_MCLK_SRC])
                mclk_select <= GCFG_MCLK_XTAL;
            else
                mclk_select <= GCFG_MCLK_RING;
            ring_osc_on <= ~mcfg1_next[BIT_ROSC_PD];
            device_in_reset <= mcfg1_next[BIT_SOFT_RST];
            memory_bank_select <= bank_next[BIT_BANK];
            clock_doubler_on <= mcfg1_next[BIT_DBL];
            // unused mode 11 treated as powered down
            crystal_pin_mode <= (mcfg1_next[POS_XMODE +: 2] == XMODE_SE ||
                mcfg1_next[POS_XMODE +: 2] == XMODE_XTAL) ?
                mcfg1_next[POS_XMODE +: 2] : XMODE_OFF;
            ext_switch_gpio_source <= mcfg2_next[POS_EXTSRC +: 2];
            ext_switch_valid <= ext_switch_on;
            nco_spread_block_on <= pll_enable_reg_next[BIT_NCO];
            analog_pll_on <= pll_enable_reg_next[BIT_APLL];
            input_clk_on <= input_clock_enable_reg_next[2:0];
            output_clk_on <= output_clock_enable_reg_next[2:0];
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign pin_out = pout_reg;
    assign pin_oe = poe_reg;

    // checks
    a_soft_rst_clears: assert property (@(posedge mclk) disable iff (rst)
        soft_rst |=> (input_clock_enable_reg_reg == RST_ZERO && output_clock_enable_reg_reg == RST_ZERO))
        else $error("soft reset left enables set");
    a_strap_restore: assert property (@(posedge mclk) disable iff (rst)
        soft_rst |=> pcfg1_reg == $past(strap_reg))
        else $error("pin config not restored from strap");
    a_mclk_override: assert property (@(posedge mclk) disable iff (rst)
        mcfg1_reg[BIT_MCLK_IN1] |-> mclk_select == GCFG_MCLK_IN1)
        else $error("input one did not override master clock");
    a_ring_after_rst: assert property (@(posedge mclk)
        $fell(rst) |-> mclk_select == GCFG_MCLK_RING && ring_osc_on)
        else $error("ring oscillator not selected after reset");
    a_rosc_follow: assert property (@(posedge mclk) disable iff (rst)
        ring_osc_on == ~mcfg1_reg[BIT_ROSC_PD])
        else $error("ring oscillator power mismatch");
    a_xmode_legal: assert property (@(posedge mclk) disable iff (rst)
        crystal_pin_mode != 2'h3)
        else $error("unused crystal mode driven");
    a_enable_map: assert property (@(posedge mclk) disable iff (rst)
        input_clk_on == input_clock_enable_reg_reg[2:0] && output_clk_on == output_clock_enable_reg_reg[2:0]
        && analog_pll_on == pll_enable_reg_reg[BIT_APLL])
        else $error("clock enables do not follow registers");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
        (input_clock_enable_reg_reg & ~MASK_INPUT_CLOCK_ENABLE_REG) == 8'h00 && (mcfg2_reg & ~MASK_MCFG2) == 8'h00)
        else $error("reserved bit set");
    a_pin_hi: assert property (@(posedge mclk)
        disable iff (rst || soft_rst)
        p0.cfg == PIN_OUT_HI |=> pin_oe[0] && pin_out[0])
        else $error("pin 0 not driving high");
    a_read_state: assert property (@(posedge mclk) disable iff (rst)
        reg_rd && hit(reg_addr, ADDR_PSTATE) && !bank_reg[BIT_BANK]
        |=> reg_rvalid && reg_rdata[1:0] == $past(lvl))
        else $error("pin state read wrong");
    a_bank_block: assert property (@(posedge mclk) disable iff (rst)
        bank_reg[BIT_BANK] && !soft_rst
        |=> $stable(input_clock_enable_reg_reg) && $stable(mcfg1_reg))
        else $error("register written while memory bank mapped");
    c_soft_rst: cover property (@(posedge mclk) soft_rst);
    c_xtal_sel: cover property (@(posedge mclk) mclk_select == GCFG_MCLK_XTAL);
    c_status_od: cover property (@(posedge mclk) p0.cfg == PIN_ST_OD1);
    c_bank_mem: cover property (@(posedge mclk) memory_bank_select);
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    import gcfg_pkg::*;
    // stimulus, all driven by the bench
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] strap = 8'h00;
    logic [255:0] stat = '0;
    logic ext_sw = 1'b0;
    logic [1:0] ext_pin = 2'h0;
    logic [7:0] psel0 = 8'h00;
    logic [7:0] psel1 = 8'h00;
    // design outputs
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [1:0] pin_in, pin_out, pin_oe;
    logic bank_o, dir_o, rosc_o, dbl_o, swv_o, nco_o, apll_o;
    gcfg_mclk_t msel_o;
    logic [1:0] xm_o, sws_o;
    logic [2:0] ic_o, oc_o;
    // reference model state
    int mismatches = 0;
    int check_count = 0;
    int mr [16];
    int mk [16] = '{MASK_BANK, 0, 0, 0, 0, 0, 0, 0, 0, MASK_MCFG1,
        MASK_MCFG2, MASK_PLL_ENABLE_REG, MASK_INPUT_CLOCK_ENABLE_REG, MASK_OUTPUT_CLOCK_ENABLE_REG, MASK_PCFG1, 0};
    int strap_cap;
    logic [31:0] seed = 32'hB4E6D784;

    always #5 mclk = ~mclk;
    // wire level: the device wins while it drives, else the outside
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pin);

    gcfg_regs i_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .strap_pin_cfg(strap), .status_bytes(stat), .ext_switch_on(ext_sw),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .memory_bank_select(bank_o), .device_in_reset(dir_o),
        .mclk_select(msel_o), .ring_osc_on(rosc_o),
        .clock_doubler_on(dbl_o), .crystal_pin_mode(xm_o),
        .ext_switch_gpio_source(sws_o), .ext_switch_valid(swv_o),
        .nco_spread_block_on(nco_o), .analog_pll_on(apll_o),
        .input_clk_on(ic_o), .output_clk_on(oc_o),
        .pin0_status_select(psel0), .pin1_status_select(psel1));

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time,
                what, got, exp);
        end
    endtask

    // expected {drive enable, drive value} of one pin
    function automatic logic [1:0] pexp(input int i);
        logic [3:0] code;
        logic s;
        code = mr[14][4*i +: 4];
        s = stat[i ? psel1 : psel0];
        if (mr[9][7]) begin
            return 2'b00;
        end
        case (code)
            4'h2: return 2'b10;
            4'h3: return 2'b11;
            4'h4: return {1'b1, s};
            4'h5: return {1'b1, ~s};
            4'h6: return {~s, 1'b0};
            4'h7: return {s, 1'b0};
            default: return 2'b00;
        endcase
    endfunction

    function automatic logic [7:0] mread(input int a);
        logic [1:0] p0, p1;
        logic [7:0] c;
        p0 = pexp(0);
        p1 = pexp(1);
        c = mr[14][7:0];
        // bank 1 hides every address from 0x01 up
        if (a > 15 || (mr[0][0] && a != 0)) begin
            return 8'h00;
        end
        if (a == 15) begin
            return {6'h00, (p1[1] ? p1[0] : ext_pin[1]) ^ (c[7:4] == 4'h1),
                (p0[1] ? p0[0] : ext_pin[0]) ^ (c[3:0] == 4'h1)};
        end
        return mr[a][7:0];
    endfunction

    // soft reset wipes all but itself and the strapped pin config; bank 1 hides 0x01 and up
    function automatic void mwrite(input int a, input logic [7:0] d);
        if (a > 15 || (mr[0][0] && a != 0)) begin
            return;
        end
        if (a == 9 && d[7]) begin
            mr = '{default: 0};
            mr[9] = 128;
            mr[14] = strap_cap;
        end else if (!(mr[9][7] && a != 9)) begin
            // while held, a write of 0x09 can only clear it
            mr[a] = mr[9][7] ? 0 : d & mk[a];
        end
    endfunction

    task automatic chk_ctl();
        logic [7:0] m1, e, g;
        logic [1:0] p0, p1;
        m1 = mr[9][7:0];
        p0 = pexp(0);
        p1 = pexp(1);
        e = {mr[0][0], m1[7], m1[5] ? 2'h2 : {1'b0, m1[4]}, ~m1[3], m1[2],
            m1[1:0] == 2'h3 ? 2'h0 : m1[1:0]};
        g = {bank_o, dir_o, msel_o, rosc_o, dbl_o, xm_o};
        cmp(g, e, "clocks");
        e = {mr[10][6:5], ext_sw, mr[11][4], mr[11][0], mr[12][2:0]};
        g = {sws_o, swv_o, nco_o, apll_o, ic_o};
        cmp(g, e, "enables");
        e = {mr[13][2:0], p1[1] & p1[0], p0[1] & p0[0], p1[1], p0[1], 1'b0};
        g = {oc_o, pin_out[1] & p1[1], pin_out[0] & p0[1], pin_oe, 1'b0};
        cmp(g, e, "outputs and pins");
    endtask

    // one write, then the controls are compared once settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        mwrite(a, d);
        // pin drive trails its config by one edge, so wait it out
        @(posedge mclk);
        @(negedge mclk);
        chk_ctl();
    endtask

    // read answer has a fixed latency of one edge
    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        e = mread(a);
        @(negedge mclk);
        cmp({7'h00, reg_rvalid}, 8'h01, "read valid");
        cmp(reg_rdata, e, "read data");
    endtask

    task automatic stir();
        logic [31:0] r;
        @(posedge mclk);
        for (int k = 0; k < 8; k++) begin
            stat[32*k +: 32] <= rnd();
        end
        r = rnd();
        psel0 <= r[7:0];
        psel1 <= r[15:8];
        ext_pin <= r[17:16];
        ext_sw <= r[18];
    endtask

    // watchdog against a hang
    initial begin
        repeat (100000) @(posedge mclk);
        mismatches++;
        results();
    end

    initial begin
        logic [31:0] r;
        int a;
        r = rnd();
        strap <= r[7:0];
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        strap_cap = strap;
        mr[14] = strap_cap;
        strap <= ~r[7:0]; // a later strap must not reach a soft reset
        // outputs leave their reset values at the first edge with reset low
        @(posedge mclk);
        @(negedge mclk);
        chk_ctl();
        for (a = 0; a < 17; a++) begin
            rd(a == 16 ? 8'h40 : a[7:0]);
        end
        // orderly bring-up: pll, crystal, then doubler and source
        wr(8'h0B, 8'h01);
        wr(8'h09, 8'h01);
        wr(8'h09, 8'h15);
        wr(8'h09, 8'h1D);
        wr(8'h0B, 8'h11);
        wr(8'h09, 8'h3F);
        for (int n = 0; n < 60; n++) begin
            stir();
            r = rnd();
            a = 9 + int'(r[10:8]) % 6;
            wr(a[7:0], a == 9 ? r[7:0] & 8'h7F : r[7:0]);
            rd(a[7:0]);
            rd(8'h0F);
        end
        for (int c = 0; c < 16; c++) begin
            repeat (2) begin
                stir();
                wr(8'h0E, {c[3:0], 4'hF - c[3:0]});
                rd(8'h0F);
            end
        end
        wr(8'h0C, 8'h05);
        wr(8'h00, 8'hFF);
        rd(8'h00);
        wr(8'h0C, 8'h02);
        rd(8'h0C);
        wr(8'h00, 8'h00);
        rd(8'h0C);
        wr(8'h0D, 8'h07);
        wr(8'h0E, 8'h23);
        // bench stands for a later revision, where soft reset is allowed
        wr(8'h09, 8'h80);
        rd(8'h09);
        rd(8'h0D);
        rd(8'h0E);
        wr(8'h0C, 8'h07);
        rd(8'h0C);
        wr(8'h09, 8'h00);
        rd(8'h0E);
        wr(8'h0C, 8'h01);
        results();
    end
endmodule
